// [rtl/adc_readout_ctrl.sv]
// Conversion control, busy, result registers and parallel/byte/serial readout
module adc_readout_ctrl (
  input wire logic sys_clk_i, // System clock, 200 MHz
  input wire logic sys_rst_i, // Asynchronous reset, active high
  input wire logic rd_sclk_i, // Read strobe, or serial clock in serial mode
  input wire logic cs_n_i, // Chip select, active low
  input wire logic start_group_a_i, // Start for channels one to four
  input wire logic start_group_b_i, // Start for channels five to eight
  input wire logic reset_pin_i, // Device reset pin, active high
  input wire logic interface_select_i, // Low parallel, high serial or byte
  input wire logic [15:0] parallel_result_bus_i, // Data lines as seen on the pins
  input wire adc_readout_pkg::result_set_t sample_data_i, // Converter core results
  output logic [15:0] parallel_result_bus_o, // Data lines driven value
  output logic [15:0] parallel_result_bus_oe_n_o, // Data line enables, low drives
  output logic busy_o, // Conversion in progress
  output logic hold_group_a_o, // Track-and-hold of channels one to four in hold
  output logic hold_group_b_o, // Track-and-hold of channels five to eight in hold
  output logic first_channel_marker_o, // First channel being read
  output logic first_channel_marker_oe_n_o // Marker enable, low drives
);

  // ==========================================================================
  // Input synchronisers
  adc_readout_pkg::pins_t pins_raw;
  adc_readout_pkg::pins_t sync1_r;
  adc_readout_pkg::pins_t sync2_r;
  adc_readout_pkg::pins_t prev_r;

  assign pins_raw = '{cs_n: cs_n_i, rd_sclk: rd_sclk_i, start_a: start_group_a_i,
                      start_b: start_group_b_i, reset_pin: reset_pin_i,
                      if_sel: interface_select_i,
                      line15: parallel_result_bus_i[adc_readout_pkg::BYTE_MODE_LINE],
                      line14: parallel_result_bus_i[adc_readout_pkg::BYTE_ORDER_LINE]};

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sync1_r <= '{cs_n: 1'b1, rd_sclk: 1'b1, default: 1'b0};
      sync2_r <= '{cs_n: 1'b1, rd_sclk: 1'b1, default: 1'b0};
      prev_r <= '{cs_n: 1'b1, rd_sclk: 1'b1, default: 1'b0};
    end else begin
      sync1_r <= pins_raw;
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
    end
  end

  function automatic adc_readout_pkg::if_mode_t decode_mode(input logic if_sel, input logic line15);
    if (!if_sel) begin
      decode_mode = adc_readout_pkg::MODE_PARALLEL;
    end else if (line15) begin
      decode_mode = adc_readout_pkg::MODE_BYTE;
    end else begin
      decode_mode = adc_readout_pkg::MODE_SERIAL;
    end
  endfunction : decode_mode

  adc_readout_pkg::if_mode_t mode;
  logic start_a_rise;
  logic start_b_rise;
  logic rst_pin_rise;
  logic cs_fall;
  logic strobe_fall;

  assign mode = decode_mode(sync2_r.if_sel, sync2_r.line15);
  assign start_a_rise = sync2_r.start_a && !prev_r.start_a;
  assign start_b_rise = sync2_r.start_b && !prev_r.start_b;
  assign rst_pin_rise = sync2_r.reset_pin && !prev_r.reset_pin;
  assign cs_fall = !sync2_r.cs_n && prev_r.cs_n;
  assign strobe_fall = !sync2_r.cs_n && !sync2_r.rd_sclk && prev_r.rd_sclk;

  // ==========================================================================
  // Conversion control
  adc_readout_pkg::conv_state_t state_r;
  adc_readout_pkg::conv_state_t state_nxt;
  logic [9:0] conv_cnt_r;
  logic hold_a_r;
  logic hold_b_r;
  logic busy_r;
  logic finish;

  assign finish = (state_r == adc_readout_pkg::CONV_RUN) && (conv_cnt_r == adc_readout_pkg::CONV_LAST);

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      adc_readout_pkg::CONV_IDLE: begin
        if (start_a_rise && start_b_rise) begin
          state_nxt = adc_readout_pkg::CONV_RUN;
        end else if (start_a_rise || start_b_rise) begin
          state_nxt = adc_readout_pkg::CONV_ARMED;
        end
      end
      adc_readout_pkg::CONV_ARMED: begin
        if ((hold_a_r || start_a_rise) && (hold_b_r || start_b_rise)) begin
          state_nxt = adc_readout_pkg::CONV_RUN;
        end
      end
      adc_readout_pkg::CONV_RUN: begin
        if (finish) begin
          state_nxt = adc_readout_pkg::CONV_IDLE;
        end
      end
      default: begin
        state_nxt = adc_readout_pkg::CONV_IDLE;
      end
    endcase
    if (rst_pin_rise) begin
      state_nxt = adc_readout_pkg::CONV_IDLE;
    end
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_r <= adc_readout_pkg::CONV_IDLE;
      busy_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      busy_r <= (state_nxt == adc_readout_pkg::CONV_RUN);
    end
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      conv_cnt_r <= '0;
    end else if (state_r == adc_readout_pkg::CONV_RUN && !finish) begin
      conv_cnt_r <= conv_cnt_r + 10'h001;
    end else begin
      conv_cnt_r <= '0;
    end
  end

  // Starts are sampled only outside busy, so a late edge cannot re-arm a hold
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      hold_a_r <= 1'b0;
      hold_b_r <= 1'b0;
    end else if (rst_pin_rise || finish) begin
      hold_a_r <= 1'b0;
      hold_b_r <= 1'b0;
    end else if (!busy_r) begin
      hold_a_r <= hold_a_r || start_a_rise;
      hold_b_r <= hold_b_r || start_b_rise;
    end
  end

  // ==========================================================================
  // Output result registers
  adc_readout_pkg::result_set_t out_r;

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      out_r <= '0;
    end else if (rst_pin_rise) begin
      out_r <= '0;
    end else if (finish) begin
      out_r <= sample_data_i;
    end
  end

  // ==========================================================================
  // Parallel and byte readout
  logic [2:0] read_ch_r;
  logic byte_phase_r;
  logic [15:0] bus_data_r;
  logic [15:0] bus_oe_n_r;
  adc_readout_pkg::result_t cur_word;
  logic byte_read;

  assign cur_word = out_r.word[read_ch_r];
  assign byte_read = (mode == adc_readout_pkg::MODE_BYTE);

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      read_ch_r <= '0;
      byte_phase_r <= 1'b0;
    end else if (rst_pin_rise || finish) begin
      read_ch_r <= '0;
      byte_phase_r <= 1'b0;
    end else if (strobe_fall && mode != adc_readout_pkg::MODE_SERIAL) begin
      byte_phase_r <= byte_read && !byte_phase_r;
      if (!byte_read || byte_phase_r) begin
        read_ch_r <= read_ch_r + 3'h1;
      end
    end
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      bus_data_r <= '0;
    end else if (rst_pin_rise) begin
      bus_data_r <= '0;
    end else if (strobe_fall && mode == adc_readout_pkg::MODE_PARALLEL) begin
      bus_data_r <= cur_word;
    end else if (strobe_fall && byte_read) begin
      // Upper byte first when the order line is high, lower first otherwise
      bus_data_r <= {8'h00, (sync2_r.line14 ^ byte_phase_r) ? cur_word[15:8] : cur_word[7:0]};
    end
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      bus_oe_n_r <= adc_readout_pkg::BUS_ALL_OFF;
    end else if (sync2_r.cs_n) begin
      bus_oe_n_r <= adc_readout_pkg::BUS_ALL_OFF;
    end else if (mode == adc_readout_pkg::MODE_SERIAL) begin
      bus_oe_n_r <= adc_readout_pkg::BUS_SERIAL_ON;
    end else if (sync2_r.rd_sclk) begin
      bus_oe_n_r <= adc_readout_pkg::BUS_ALL_OFF;
    end else if (byte_read) begin
      bus_oe_n_r <= adc_readout_pkg::BUS_LOW_BYTE_ON;
    end else begin
      bus_oe_n_r <= '0;
    end
  end

  // ==========================================================================
  // First channel marker
  logic marker_r;
  logic marker_oe_n_r;
  logic [3:0] sclk_fall_cnt_r;
  logic sclk_fall;

  assign sclk_fall = !sync2_r.cs_n && !sync2_r.rd_sclk && prev_r.rd_sclk;

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      marker_oe_n_r <= 1'b1;
    end else begin
      marker_oe_n_r <= sync2_r.cs_n;
    end
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sclk_fall_cnt_r <= '0;
    end else if (cs_fall) begin
      sclk_fall_cnt_r <= '0;
    end else if (sclk_fall && sclk_fall_cnt_r != adc_readout_pkg::MARKER_LAST_FALL) begin
      sclk_fall_cnt_r <= sclk_fall_cnt_r + 4'h1;
    end
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      marker_r <= 1'b0;
    end else if (rst_pin_rise) begin
      marker_r <= 1'b0;
    end else if (mode == adc_readout_pkg::MODE_SERIAL) begin
      if (cs_fall) begin
        marker_r <= 1'b1;
      end else if (sclk_fall && sclk_fall_cnt_r == adc_readout_pkg::MARKER_LAST_FALL) begin
        marker_r <= 1'b0;
      end
    end else if (strobe_fall) begin
      marker_r <= (read_ch_r == 3'h0) && !byte_phase_r;
    end
  end

  // ==========================================================================
  // Serial shifter on the host's serial clock
  // Clock stands still between frames; select high clears the frame state.
  // Results only change at the end of busy or on a reset pin edge, when no read may be running, so
  // they are read here as quasi-static words.
  logic [5:0] bit_cnt_r;
  logic sclk_seen_r;
  logic ser_a_r;
  logic ser_b_r;
  logic [5:0] next_pos;

  function automatic logic pick_bit(input adc_readout_pkg::result_set_t set, input logic upper,
                                    input logic [5:0] pos);
    logic [2:0] ch;
    ch = {upper, pos[5:4]};
    pick_bit = set.word[ch][4'hf - pos[3:0]];
  endfunction : pick_bit

  assign next_pos = bit_cnt_r + 6'h01;

  always_ff @(posedge rd_sclk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      bit_cnt_r <= '0;
      sclk_seen_r <= 1'b0;
      ser_a_r <= 1'b0;
      ser_b_r <= 1'b0;
    end else begin
      bit_cnt_r <= next_pos;
      sclk_seen_r <= 1'b1;
      ser_a_r <= pick_bit(out_r, 1'b0, next_pos);
      ser_b_r <= pick_bit(out_r, 1'b1, next_pos);
    end
  end

  logic ser_a;
  logic ser_b;

  // Before the first serial clock edge the MSB of the first result shows
  assign ser_a = sclk_seen_r ? ser_a_r : pick_bit(out_r, 1'b0, 6'h00);
  assign ser_b = sclk_seen_r ? ser_b_r : pick_bit(out_r, 1'b1, 6'h00);

  // ==========================================================================
  // Outputs
  always_comb begin
    parallel_result_bus_o = bus_data_r;
    if (mode == adc_readout_pkg::MODE_SERIAL) begin
      parallel_result_bus_o = '0;
      parallel_result_bus_o[adc_readout_pkg::SER_LINE_A] = ser_a;
      parallel_result_bus_o[adc_readout_pkg::SER_LINE_B] = ser_b;
    end
  end

  assign parallel_result_bus_oe_n_o = bus_oe_n_r;
  assign busy_o = busy_r;
  assign hold_group_a_o = hold_a_r;
  assign hold_group_b_o = hold_b_r;
  assign first_channel_marker_o = marker_r;
  assign first_channel_marker_oe_n_o = marker_oe_n_r;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (sys_rst_i);

  chk_busy_both_holds: assert property ($rose(busy_r) |-> hold_a_r && hold_b_r)
    else $error("busy rose without both groups in hold");

  chk_busy_bounded: assert property ($rose(busy_r) |-> ##[1:900] !busy_r)
    else $error("busy did not fall after conversion time");

  chk_result_load: assert property (finish && !rst_pin_rise |=> out_r == $past(sample_data_i) && !busy_r)
    else $error("results not loaded as busy fell");

  chk_start_ignored: assert property (busy_r && start_a_rise && !finish && !rst_pin_rise |=> busy_r)
    else $error("start edge disturbed running conversion");

  chk_hold_on_start: assert property (!busy_r && start_a_rise && !rst_pin_rise |=> hold_a_r)
    else $error("group A not held after start edge");

  chk_reset_abort: assert property (rst_pin_rise |=> !busy_r && !hold_a_r && !hold_b_r)
    else $error("reset did not abort conversion");

  chk_reset_clear: assert property (rst_pin_rise |=> out_r == '0 && bus_data_r == '0)
    else $error("reset did not clear result registers");

  chk_marker_first: assert property (strobe_fall && mode != adc_readout_pkg::MODE_SERIAL && !finish
      && !rst_pin_rise && read_ch_r == 3'h0 && !byte_phase_r |=> marker_r)
    else $error("marker not set by first channel read");
  chk_marker_next: assert property (strobe_fall && mode != adc_readout_pkg::MODE_SERIAL && !finish
      && !rst_pin_rise && (read_ch_r != 3'h0 || byte_phase_r) |=> !marker_r)
    else $error("marker not cleared by following read");

  chk_marker_tristate: assert property (sync2_r.cs_n |=> marker_oe_n_r)
    else $error("marker driven while deselected");

  chk_parallel_drive: assert property (mode == adc_readout_pkg::MODE_PARALLEL && $stable(mode)
      && (sync2_r.cs_n || sync2_r.rd_sclk) |=> bus_oe_n_r == adc_readout_pkg::BUS_ALL_OFF)
    else $error("parallel bus driven without select and read");

endmodule : adc_readout_ctrl

// [rtl/adc_readout_pkg.sv]
// Constants and types shared by the converter control and readout logic
package adc_readout_pkg;

  // ==========================================================================
  // Sizes
  localparam int unsigned NUM_CH = 8;
  localparam int unsigned HALF_CH = 4;
  localparam int unsigned RES_W = 16;
  localparam int unsigned BYTE_W = 8;

  // ==========================================================================
  // Timing
  localparam int unsigned SYS_CLK_PERIOD_NS = 5;
  localparam int unsigned CONV_TIME_NS = 4000;
  localparam int unsigned CONV_CYCLES = (CONV_TIME_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
  localparam logic [9:0] CONV_LAST = 10'(CONV_CYCLES - 1);
  localparam logic [3:0] MARKER_LAST_FALL = 4'hf;

  // ==========================================================================
  // Data line roles
  localparam int unsigned SER_LINE_A = 7;
  localparam int unsigned SER_LINE_B = 8;
  localparam int unsigned BYTE_ORDER_LINE = 14;
  localparam int unsigned BYTE_MODE_LINE = 15;
  localparam logic [15:0] BUS_ALL_OFF = 16'hffff;
  localparam logic [15:0] BUS_LOW_BYTE_ON = 16'hff00;
  localparam logic [15:0] BUS_SERIAL_ON = 16'hfe7f;

  // ==========================================================================
  // Types
  typedef logic [RES_W-1:0] result_t;

  typedef struct packed {
    result_t [NUM_CH-1:0] word;
  } result_set_t;

  typedef struct packed {
    logic cs_n;
    logic rd_sclk;
    logic start_a;
    logic start_b;
    logic reset_pin;
    logic if_sel;
    logic line15;
    logic line14;
  } pins_t;

  typedef enum logic [1:0] {
    MODE_PARALLEL,
    MODE_SERIAL,
    MODE_BYTE
  } if_mode_t;

  typedef enum logic [1:0] {
    CONV_IDLE,
    CONV_ARMED,
    CONV_RUN
  } conv_state_t;

endpackage : adc_readout_pkg

// [sim/adc_host_model.sv]
// Host-side partner model: start, reset, mode and read pins of the converter
module adc_host_model (
  input wire logic sys_clk_i, // System clock
  input wire logic [15:0] bus_i, // Resolved data lines
  input wire logic marker_i, // Resolved first-channel marker line
  output adc_readout_pkg::pins_t pins_o // Host-driven pins
);
  timeunit 1ns;
  timeprecision 100ps;

  // ==========================================================================
  // Pin drivers
  initial begin
    pins_o = '{cs_n: 1'b1, rd_sclk: 1'b1, default: 1'b0};
  end

  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask : tick

  task automatic set_start(input logic a, input logic b);
    tick(1);
    pins_o.start_a = a;
    pins_o.start_b = b;
  endtask : set_start

  task automatic set_mode(input logic sel, input logic l15, input logic l14);
    tick(1);
    pins_o.if_sel = sel;
    pins_o.line15 = l15;
    pins_o.line14 = l14;
  endtask : set_mode

  task automatic set_cs(input logic lvl);
    tick(1);
    pins_o.cs_n = lvl;
    tick(4);
  endtask : set_cs

  // 20 cycles at 5 ns gives the typical 100 ns pulse
  task automatic pulse_reset();
    tick(1);
    pins_o.reset_pin = 1'b1;
    tick(20);
    pins_o.reset_pin = 1'b0;
  endtask : pulse_reset

  // One strobe; held well past the sync latency before sampling
  task automatic read_word(output logic [15:0] d, output logic m);
    tick(1);
    pins_o.rd_sclk = 1'b0;
    tick(6);
    d = bus_i;
    m = marker_i;
    pins_o.rd_sclk = 1'b1;
    tick(6);
  endtask : read_word

  // Serial clock runs only inside the frame, offset from the system clock
  task automatic read_serial(output logic [63:0] a, output logic [63:0] b, output logic m0, output logic m1,
                             output logic m2);
    tick(1);
    pins_o.cs_n = 1'b0;
    tick(4);
    m0 = marker_i;
    #2.3;
    for (int i = 0; i < 64; i++) begin
      #80 pins_o.rd_sclk = 1'b0;
      // Sampled mid-period, never in the step of the rising edge that shifts
      a[63-i] = bus_i[adc_readout_pkg::SER_LINE_A];
      b[63-i] = bus_i[adc_readout_pkg::SER_LINE_B];
      if (i == 15) begin
        m1 = marker_i;
      end
      if (i == 16) begin
        m2 = marker_i;
      end
      #80 pins_o.rd_sclk = 1'b1;
    end
    tick(1);
    pins_o.cs_n = 1'b1;
    tick(4);
  endtask : read_serial
endmodule : adc_host_model

// [sim/tb.sv]
// Testbench: conversion, parallel/byte/serial readout, start and reset cases
`define CHK(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin miscompares++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, (exp), (got)); end end
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {logic sel; logic l15; logic l14;} row_t;
  row_t rows [4] = '{'{1'b0, 1'b0, 1'b0}, '{1'b1, 1'b1, 1'b1}, '{1'b1, 1'b1, 1'b0}, '{1'b1, 1'b0, 1'b0}};
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic flip = 1'b0;
  adc_readout_pkg::pins_t pins;
  adc_readout_pkg::result_set_t samples;
  logic [15:0] bus_o, oe_n, d, w;
  logic busy, hold_a, hold_b, marker, marker_oe_n, m, m0, m1;
  logic [63:0] sa, sb;
  int miscompares = 0;
  int comparisons = 0;
  int cycles = 0;
  int n;
  // Released lines toggle, except lines 15 and 14 which carry the mode when if_sel is high, so a stale value never passes as data
  wire logic [15:0] drv = pins.if_sel ? {pins.line15, pins.line14, {14{flip}}} : {16{flip}};
  wire logic [15:0] bus_pin = (bus_o & ~oe_n) | (drv & oe_n);
  wire logic marker_pin = marker_oe_n ? flip : marker;

  always #2.5 sys_clk = ~sys_clk;

  adc_readout_ctrl i_adc_readout_ctrl (
    .sys_clk_i(sys_clk), .sys_rst_i(sys_rst), .rd_sclk_i(pins.rd_sclk), .cs_n_i(pins.cs_n),
    .start_group_a_i(pins.start_a), .start_group_b_i(pins.start_b), .reset_pin_i(pins.reset_pin),
    .interface_select_i(pins.if_sel), .parallel_result_bus_i(bus_pin), .sample_data_i(samples),
    .parallel_result_bus_o(bus_o), .parallel_result_bus_oe_n_o(oe_n), .busy_o(busy),
    .hold_group_a_o(hold_a), .hold_group_b_o(hold_b), .first_channel_marker_o(marker),
    .first_channel_marker_oe_n_o(marker_oe_n));

  adc_host_model i_adc_host_model (.sys_clk_i(sys_clk), .bus_i(bus_pin), .marker_i(marker_pin), .pins_o(pins));

  // ==========================================================================
  // Helpers
  task automatic final_report();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : final_report

  always @(posedge sys_clk) begin
    flip <= ~flip;
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      miscompares++;
      final_report();
    end
  end

  task automatic fill(input logic [15:0] base);
    for (int k = 0; k < 8; k++) samples.word[k] = base + 16'(k) * 16'h1111;
  endtask : fill

  task automatic wait_idle(output int cnt);
    cnt = 0;
    while (busy === 1'b1 && cnt < 2000) begin
      @(negedge sys_clk);
      cnt++;
    end
  endtask : wait_idle

  task automatic run_conv();
    int k;
    i_adc_host_model.set_start(1'b0, 1'b0);
    i_adc_host_model.tick(4);
    i_adc_host_model.set_start(1'b1, 1'b1);
    k = 0;
    while (busy !== 1'b1 && k < 20) begin
      @(negedge sys_clk);
      k++;
    end
    wait_idle(k);
    `CHK("busy_width", adc_readout_pkg::CONV_CYCLES, k)
  endtask : run_conv

  // ==========================================================================
  // Main sequence
  initial begin
    fill(16'hc3a0);
    repeat (6) @(negedge sys_clk);
    sys_rst = 1'b0;
    i_adc_host_model.pulse_reset();
    i_adc_host_model.tick(6);
    `CHK("idle_bus", adc_readout_pkg::BUS_ALL_OFF, oe_n)
    `CHK("idle_marker_oe", 1'b1, marker_oe_n)
    `CHK("idle_busy", 1'b0, busy)
    for (int r = 0; r < 4; r++) begin
      i_adc_host_model.set_mode(rows[r].sel, rows[r].l15, rows[r].l14);
      run_conv();
      i_adc_host_model.set_cs(1'b0);
      `CHK("marker_on", 1'b0, marker_oe_n)
      if (rows[r].sel && !rows[r].l15) begin
        i_adc_host_model.read_serial(sa, sb, m0, m1, m);
        `CHK("serial_a", {samples.word[0], samples.word[1], samples.word[2], samples.word[3]}, sa)
        `CHK("serial_b", {samples.word[4], samples.word[5], samples.word[6], samples.word[7]}, sb)
        `CHK("marker_ser_hi", 1'b1, m0)
        `CHK("marker_ser_16", 1'b1, m1)
        `CHK("marker_ser_lo", 1'b0, m)
      end else begin
        n = rows[r].sel ? 16 : 8;
        for (int k = 0; k < n; k++) begin
          i_adc_host_model.read_word(d, m);
          `CHK("marker_rd", (k == 0), m)
          w = samples.word[rows[r].sel ? k / 2 : k];
          if (rows[r].sel) begin
            `CHK("byte_data", (((k % 2) == 0) == rows[r].l14) ? w[15:8] : w[7:0], d[7:0])
          end else begin
            `CHK("word_data", w, d)
          end
        end
        `CHK("bus_released", adc_readout_pkg::BUS_ALL_OFF, oe_n)
      end
      i_adc_host_model.set_cs(1'b1);
      `CHK("marker_off", 1'b1, marker_oe_n)
    end
    // Staggered group starts, then an edge during busy
    i_adc_host_model.set_start(1'b0, 1'b0);
    i_adc_host_model.tick(4);
    i_adc_host_model.set_start(1'b1, 1'b0);
    i_adc_host_model.tick(8);
    `CHK("hold_a", 1'b1, hold_a)
    `CHK("hold_b_wait", 1'b0, hold_b)
    `CHK("busy_one", 1'b0, busy)
    i_adc_host_model.set_start(1'b1, 1'b1);
    i_adc_host_model.tick(8);
    `CHK("hold_b", 1'b1, hold_b)
    `CHK("busy_both", 1'b1, busy)
    i_adc_host_model.set_start(1'b0, 1'b0);
    i_adc_host_model.tick(100);
    i_adc_host_model.set_start(1'b1, 1'b1);
    wait_idle(n);
    i_adc_host_model.tick(40);
    `CHK("busy_ignored", 1'b0, busy)
    // Reset pin during conversion with the chip selected, then a read of the cleared result
    fill(16'h5a10);
    i_adc_host_model.set_mode(1'b0, 1'b0, 1'b0);
    i_adc_host_model.set_start(1'b0, 1'b0);
    i_adc_host_model.tick(4);
    i_adc_host_model.set_start(1'b1, 1'b1);
    i_adc_host_model.tick(50);
    `CHK("busy_pre", 1'b1, busy)
    i_adc_host_model.set_cs(1'b0);
    i_adc_host_model.pulse_reset();
    i_adc_host_model.tick(6);
    `CHK("busy_abort", 1'b0, busy)
    `CHK("hold_abort", 1'b0, hold_a | hold_b)
    i_adc_host_model.read_word(d, m);
    `CHK("cleared", 16'h0000, d)
    i_adc_host_model.set_cs(1'b1);
    final_report();
  end
endmodule : tb
